/* hdl/uaf_pkg.sv */
// Constants, register map and types for the address-filtering UART
package uaf_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [3:0] UAF_ADDR_DATA = 4'h0;
  localparam logic [3:0] UAF_ADDR_CTL0 = 4'h1;
  localparam logic [3:0] UAF_ADDR_CTL1 = 4'h2;
  localparam logic [3:0] UAF_ADDR_STAT = 4'h3;
  localparam logic [3:0] UAF_ADDR_IMSK = 4'h4;
  localparam logic [3:0] UAF_ADDR_STN = 4'h5;
  localparam logic [3:0] UAF_ADDR_BDHI = 4'h6;
  localparam logic [3:0] UAF_ADDR_BDLO = 4'h7;
  localparam logic [3:0] UAF_ADDR_RXST = 4'h8;
  // ==========================================================
  // Control 0 fields
  localparam int UAF_C0_TXEN = 7;
  localparam int UAF_C0_RXEN = 6;
  localparam int UAF_C0_PAREN = 4;
  localparam int UAF_C0_PODD = 3;
  localparam int UAF_C0_STOP2 = 1;
  // Control 1 fields
  localparam int UAF_C1_MULTIDROP_ENABLE = 7;
  localparam int UAF_C1_MULTIDROP_SCHEME_SELECT_HI = 6;
  localparam int UAF_C1_MULTIDROP_SCHEME_SELECT_LO = 5;
  localparam int UAF_C1_MPBT = 4;
  localparam int UAF_C1_TIMER = 3;
  localparam int UAF_C1_DEPOL = 2;
  // Interrupt status bits
  localparam int UAF_IS_RXDONE = 0;
  localparam int UAF_IS_TXDONE = 1;
  localparam int UAF_IS_PERR = 2;
  localparam int UAF_IS_FERR = 3;
  localparam int UAF_IS_OVR = 4;
  localparam int UAF_IS_BRK = 5;
  localparam int UAF_IS_TMR = 6;
  // Receive status bits
  localparam int UAF_RS_ADDR = 0;
  localparam int UAF_RS_FIRST = 1;
  localparam int UAF_RS_FULL = 2;
  localparam int UAF_RS_TXBUSY = 3;
  // ==========================================================
  // Reset values
  localparam logic [7:0] UAF_RST_CTL0 = 8'h00;
  localparam logic [7:0] UAF_RST_CTL1 = 8'h00;
  localparam logic [7:0] UAF_RST_IMSK = 8'h00;
  localparam logic [7:0] UAF_RST_STN = 8'h00;
  localparam logic [15:0] UAF_RST_BAUD = 16'h0001;
  // Oversampling: sixteen ticks per bit, mid-bit at tick seven
  localparam logic [3:0] UAF_MID_TICK = 4'h7;
  localparam logic [3:0] UAF_LAST_TICK = 4'hF;
  localparam logic [3:0] UAF_BITS_DATA = 4'h8;
  // Multi-drop scheme codes
  localparam logic [1:0] UAF_MP_ADDR_IRQ = 2'h1;
  localparam logic [1:0] UAF_MP_CMP_ALL = 2'h2;
  localparam logic [1:0] UAF_MP_CMP_DATA = 2'h3;

  typedef enum logic [5:0] {
    UAF_S_IDLE = 6'b000001,
    UAF_S_START = 6'b000010,
    UAF_S_DATA = 6'b000100,
    UAF_S_NINTH = 6'b001000,
    UAF_S_STOP = 6'b010000,
    UAF_S_STOP2 = 6'b100000
  } uaf_state_t;
endpackage : uaf_pkg

/* hdl/uaf_top.sv */
// Address-filtering UART: baud divider, transmitter, receiver, register port
`timescale 1ns/1ns
module uaf_top (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic irq,
  input wire logic rxd,
  output logic txd,
  output logic drv_en
);
  import uaf_pkg::*;

  // ==========================================================
  // Registers
  logic [7:0] ctl0_r, ctl1_r, imsk_r, stn_r, stat_r, rxdata_r;
  logic [15:0] baud_divider;
  logic rx_full_r, rx_addr_r, rx_first_r;
  logic [7:0] stat_set;
  logic rd_stat, rd_data, wr_data;
  logic tx_en, rx_en, par_en, par_odd, stop2, multidrop_enable, timer_mode;
  logic [1:0] multidrop_scheme_select;
  // Transmitter activity, declared early for the status read-back
  logic tx_busy, tx_go;

  // Field decode of the control registers
  assign tx_en = ctl0_r[UAF_C0_TXEN];
  assign rx_en = ctl0_r[UAF_C0_RXEN];
  assign par_en = ctl0_r[UAF_C0_PAREN];
  assign par_odd = ctl0_r[UAF_C0_PODD];
  assign stop2 = ctl0_r[UAF_C0_STOP2];
  assign multidrop_enable = ctl1_r[UAF_C1_MULTIDROP_ENABLE];
  assign multidrop_scheme_select = ctl1_r[UAF_C1_MULTIDROP_SCHEME_SELECT_HI:UAF_C1_MULTIDROP_SCHEME_SELECT_LO];
  assign timer_mode = ctl1_r[UAF_C1_TIMER];

  // Strobes for the registers with side effects
  assign rd_stat = reg_rd && (reg_addr == UAF_ADDR_STAT);
  assign rd_data = reg_rd && (reg_addr == UAF_ADDR_DATA);
  assign wr_data = reg_wr && (reg_addr == UAF_ADDR_DATA);

  // Control register writes
  // Writes to data, status and receive status fall through here; data is taken below
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctl0_r <= UAF_RST_CTL0;
      ctl1_r <= UAF_RST_CTL1;
      imsk_r <= UAF_RST_IMSK;
      stn_r <= UAF_RST_STN;
      baud_divider <= UAF_RST_BAUD;
    end else if (reg_wr) begin
      unique case (reg_addr)
        UAF_ADDR_CTL0: ctl0_r <= reg_wdata;
        UAF_ADDR_CTL1: ctl1_r <= reg_wdata;
        UAF_ADDR_IMSK: imsk_r <= reg_wdata;
        UAF_ADDR_STN: stn_r <= reg_wdata;
        UAF_ADDR_BDHI: baud_divider[15:8] <= reg_wdata;
        UAF_ADDR_BDLO: baud_divider[7:0] <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Read data, valid in the cycle after the strobe
  // The port rests at zero whenever no read was asked for
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        UAF_ADDR_DATA: reg_rdata <= rxdata_r;
        UAF_ADDR_CTL0: reg_rdata <= ctl0_r;
        UAF_ADDR_CTL1: reg_rdata <= ctl1_r;
        UAF_ADDR_STAT: reg_rdata <= stat_r;
        UAF_ADDR_IMSK: reg_rdata <= imsk_r;
        UAF_ADDR_STN: reg_rdata <= stn_r;
        UAF_ADDR_BDHI: reg_rdata <= baud_divider[15:8];
        UAF_ADDR_BDLO: reg_rdata <= baud_divider[7:0];
        UAF_ADDR_RXST: reg_rdata <= {4'h0, tx_busy, rx_full_r, rx_first_r, rx_addr_r};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Baud divider: sixteen ticks per bit, or a plain timer
  // A divider of one ticks every cycle; zero wraps to the longest period
  logic [15:0] bcnt_r;
  logic tick_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bcnt_r <= 16'h0000;
      tick_r <= 1'b0;
    end else if (bcnt_r >= baud_divider - 16'h0001) begin
      bcnt_r <= 16'h0000;
      tick_r <= 1'b1;
    end else begin
      bcnt_r <= bcnt_r + 16'h0001;
      tick_r <= 1'b0;
    end
  end
  logic bit_tick, tmr_evt;
  // In timer mode the ticks stop the serial side and set the timer flag
  assign bit_tick = tick_r && !timer_mode;
  assign tmr_evt = tick_r && timer_mode;

  // ==========================================================
  // Transmitter
  uaf_state_t tx_st_r;
  logic [3:0] tx_tk_r, tx_bit_r;
  logic [7:0] tx_sh_r, tx_hold_r;
  logic tx_hold_v_r, tx_par_r, tx_nin_r, tx_done;
  // Busy from the start bit to the end of the last stop bit
  assign tx_busy = (tx_st_r != UAF_S_IDLE);
  // High on the tick at which an idle transmitter takes the holding register
  assign tx_go = bit_tick && (tx_st_r == UAF_S_IDLE) && tx_en && tx_hold_v_r;

  // Holding register filled by software
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_hold_r <= 8'h00;
      tx_hold_v_r <= 1'b0;
    end else if (wr_data) begin
      tx_hold_r <= reg_wdata;
      tx_hold_v_r <= 1'b1;
    end else if (tx_go) begin
      // Cleared only when the character is really taken
      tx_hold_v_r <= 1'b0;
    end
  end

  // Frame sequencer: start, 8 data, parity or ninth bit, stop(s)
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_st_r <= UAF_S_IDLE;
      tx_tk_r <= 4'h0;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 8'h00;
      tx_par_r <= 1'b0;
      tx_nin_r <= 1'b0;
      txd <= 1'b1;
    end else if (bit_tick) begin
      tx_tk_r <= tx_tk_r + 4'h1;
      unique case (tx_st_r)
        UAF_S_IDLE: begin
          tx_tk_r <= 4'h0;
          if (tx_en && tx_hold_v_r) begin
            tx_st_r <= UAF_S_START;
            tx_sh_r <= tx_hold_r;
            // Parity seed: 0 gives even, 1 gives odd after all data bits fold in
            tx_par_r <= par_odd;
            tx_nin_r <= ctl1_r[UAF_C1_MPBT];
            txd <= 1'b0;
          end
        end
        UAF_S_START: if (tx_tk_r == UAF_LAST_TICK) begin
          tx_st_r <= UAF_S_DATA;
          tx_bit_r <= 4'h0;
          txd <= tx_sh_r[0];
        end
        UAF_S_DATA: if (tx_tk_r == UAF_LAST_TICK) begin
          tx_par_r <= tx_par_r ^ tx_sh_r[0];
          tx_sh_r <= {1'b0, tx_sh_r[7:1]};
          tx_bit_r <= tx_bit_r + 4'h1;
          if (tx_bit_r == UAF_BITS_DATA - 4'h1) begin
            // Ninth slot: address mark in multi-drop mode, else parity if enabled
            if (multidrop_enable) begin
              tx_st_r <= UAF_S_NINTH;
              txd <= tx_nin_r;
            end else if (par_en) begin
              tx_st_r <= UAF_S_NINTH;
              txd <= tx_par_r ^ tx_sh_r[0];
            end else begin
              tx_st_r <= UAF_S_STOP;
              txd <= 1'b1;
            end
          end else begin
            txd <= tx_sh_r[1];
          end
        end
        UAF_S_NINTH: if (tx_tk_r == UAF_LAST_TICK) begin
          tx_st_r <= UAF_S_STOP;
          txd <= 1'b1;
        end
        UAF_S_STOP: if (tx_tk_r == UAF_LAST_TICK) begin
          tx_st_r <= stop2 ? UAF_S_STOP2 : UAF_S_IDLE;
        end
        UAF_S_STOP2: if (tx_tk_r == UAF_LAST_TICK) begin
          tx_st_r <= UAF_S_IDLE;
        end
      endcase
    end
  end
  // Transmit-done event on the last tick of the final stop bit
  assign tx_done = bit_tick && tx_tk_r == UAF_LAST_TICK &&
    ((tx_st_r == UAF_S_STOP && !stop2) || tx_st_r == UAF_S_STOP2);

  // Driver enable follows the transmitter, polarity selectable
  // Raised together with the start bit so the transceiver never misses it,
  // dropped one cycle after the final stop bit ends
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drv_en <= 1'b0;
    end else begin
      drv_en <= (tx_busy || tx_go) ^ ctl1_r[UAF_C1_DEPOL];
    end
  end

  // ==========================================================
  // Receiver: three-stage synchroniser, stable when stages 2 and 3 agree
  logic rx_s1_r, rx_s2_r, rx_s3_r, rx_in_r;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
      rx_s3_r <= 1'b1;
      rx_in_r <= 1'b1;
    end else begin
      rx_s1_r <= rxd;
      rx_s2_r <= rx_s1_r;
      rx_s3_r <= rx_s2_r;
      // Stage one feeds only stage two; a level counts once two and three agree
      if (rx_s2_r == rx_s3_r) rx_in_r <= rx_s3_r;
    end
  end

  // Receive sequencer state, shift register and running checks
  uaf_state_t rx_st_r;
  logic [3:0] rx_tk_r, rx_bit_r;
  logic [7:0] rx_sh_r;
  logic rx_par_r, rx_nin_r, rx_zero_r, rx_end;
  // Mid-bit sampling of start, data, ninth and stop bits
  // Clearing the receive enable drops any character in progress
  always_ff @(posedge clk) begin
    if (!rst_n || !rx_en) begin
      rx_st_r <= UAF_S_IDLE;
      rx_tk_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 8'h00;
      rx_par_r <= 1'b0;
      rx_nin_r <= 1'b0;
      rx_zero_r <= 1'b0;
    end else if (bit_tick) begin
      rx_tk_r <= rx_tk_r + 4'h1;
      unique case (rx_st_r)
        UAF_S_IDLE: begin
          rx_tk_r <= 4'h0;
          if (!rx_in_r) rx_st_r <= UAF_S_START;
        end
        UAF_S_START: if (rx_tk_r == UAF_MID_TICK) begin
          if (rx_in_r) begin
            rx_st_r <= UAF_S_IDLE; // glitch, not a start bit
          end else begin
            rx_st_r <= UAF_S_DATA;
            // Restart the count so every later sample lands mid-bit
            rx_tk_r <= UAF_MID_TICK + 4'h1;
            rx_bit_r <= 4'h0;
            rx_par_r <= 1'b0;
            rx_zero_r <= 1'b1;
          end
        end
        UAF_S_DATA: if (rx_tk_r == UAF_MID_TICK) begin
          rx_sh_r <= {rx_in_r, rx_sh_r[7:1]};
          rx_par_r <= rx_par_r ^ rx_in_r;
          rx_zero_r <= rx_zero_r & !rx_in_r;
          rx_bit_r <= rx_bit_r + 4'h1;
          if (rx_bit_r == UAF_BITS_DATA - 4'h1)
            rx_st_r <= (multidrop_enable || par_en) ? UAF_S_NINTH : UAF_S_STOP;
        end
        UAF_S_NINTH: if (rx_tk_r == UAF_MID_TICK) begin
          rx_nin_r <= rx_in_r;
          rx_par_r <= rx_par_r ^ rx_in_r;
          rx_zero_r <= rx_zero_r & !rx_in_r;
          rx_st_r <= UAF_S_STOP;
        end
        UAF_S_STOP: if (rx_tk_r == UAF_MID_TICK) begin
          rx_st_r <= UAF_S_IDLE;
        end
        default: rx_st_r <= UAF_S_IDLE;
      endcase
    end
  end
  // Character complete at the middle of the stop bit
  assign rx_end = rx_en && bit_tick && rx_st_r == UAF_S_STOP && rx_tk_r == UAF_MID_TICK;

  // Character qualification and multi-drop filtering
  logic is_addr, match, keep, want_irq, perr, ferr, brk;
  logic matched_r, first_pend_r;
  assign is_addr = multidrop_enable && rx_nin_r;
  assign match = (rx_sh_r == stn_r);

  // Error conditions judged on the stop-bit sample; parity is off in multi-drop mode
  assign perr = par_en && !multidrop_enable && (rx_par_r != par_odd);
  assign ferr = !rx_in_r;
  assign brk = rx_zero_r && !rx_in_r;

  always_comb begin
    keep = 1'b1;
    want_irq = 1'b1;
    // Schemes 1x: unmatched frames are not stored and flag only framing error or break
    if (multidrop_enable && multidrop_scheme_select[1]) begin
      keep = is_addr ? match : matched_r;
      want_irq = keep && !(is_addr && multidrop_scheme_select == UAF_MP_CMP_DATA);
    end else if (multidrop_enable && multidrop_scheme_select == UAF_MP_ADDR_IRQ) begin
      // Scheme 01 stores every character but only addresses set the receive-done flag
      want_irq = is_addr;
    end
  end

  // Frame match tracking and first-data flag
  // Every address character reloads the match state, whatever the scheme
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      matched_r <= 1'b0;
      first_pend_r <= 1'b0;
    end else if (rx_end && is_addr) begin
      matched_r <= match;
      first_pend_r <= match;
    end else if (rx_end && keep) begin
      first_pend_r <= 1'b0;
    end
  end

  // Receive data buffer and character flags
  // A character arriving with a data read keeps the buffer full
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rxdata_r <= 8'h00;
      rx_full_r <= 1'b0;
      rx_addr_r <= 1'b0;
      rx_first_r <= 1'b0;
    end else if (rx_end && keep) begin
      rxdata_r <= rx_sh_r;
      rx_full_r <= 1'b1;
      rx_addr_r <= is_addr;
      rx_first_r <= !is_addr && first_pend_r && multidrop_scheme_select[1];
    end else if (rd_data) begin
      rx_full_r <= 1'b0;
    end
  end

  // ==========================================================
  // Sticky interrupt status, cleared by reading it; set wins
  always_comb begin
    stat_set = 8'h00;
    stat_set[UAF_IS_RXDONE] = rx_end && want_irq;
    stat_set[UAF_IS_TXDONE] = tx_done;
    stat_set[UAF_IS_PERR] = rx_end && keep && perr;
    stat_set[UAF_IS_FERR] = rx_end && ferr;
    stat_set[UAF_IS_OVR] = rx_end && keep && rx_full_r && !rd_data;
    stat_set[UAF_IS_BRK] = rx_end && brk;
    stat_set[UAF_IS_TMR] = tmr_evt;
  end
  // Read clears the old bits; events of the same cycle still land
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      stat_r <= 8'h00;
    end else begin
      stat_r <= (rd_stat ? 8'h00 : stat_r) | stat_set;
    end
  end
  // Level interrupt from any unmasked status bit, one cycle behind status
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_r & imsk_r);
    end
  end
endmodule : uaf_top

/* testbench/uaf_monitor.sv */
// Port-level checker for the address-filtering UART
`timescale 1ns/1ns
module uaf_monitor (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic irq,
  input wire logic rxd,
  input wire logic txd,
  input wire logic drv_en
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // Frame sequences
  sequence s_start;
    $fell(txd);
  endsequence
  sequence s_start_held;
    (!txd) [*8];
  endsequence
  // ==========================================================
  // Properties
  property p_rdata_quiet;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet) else $error("read data not zero");
  property p_unmapped;
    reg_rd && reg_addr > 4'h8 |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_reset_idle;
    $rose(rst_n) |-> txd && !drv_en && !irq && reg_rdata == 8'h00;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("outputs not idle after reset");
  property p_start_low;
    s_start |-> s_start_held;
  endproperty
  a_start_low: assert property (p_start_low) else $error("start bit too short");
  property p_de_frame;
    s_start |-> drv_en [*8];
  endproperty
  a_de_frame: assert property (p_de_frame) else $error("driver enable low in frame");
  property p_de_lead;
    $rose(drv_en) |-> ##[0:40] !txd;
  endproperty
  a_de_lead: assert property (p_de_lead) else $error("no start after driver enable");
  property p_de_idle;
    $fell(drv_en) |-> txd;
  endproperty
  a_de_idle: assert property (p_de_idle) else $error("line not idle at driver release");
  property p_bit_stable;
    $changed(txd) |=> $stable(txd) [*8];
  endproperty
  a_bit_stable: assert property (p_bit_stable) else $error("line changed within a bit");
endmodule : uaf_monitor

/* testbench/uaf_node.sv */
// Serial node model on the far side of the line
`timescale 1ns/1ns
module uaf_node #(
  parameter int BIT_CYC = 16
) (
  input wire logic clk,
  input wire logic txd,
  output logic rxd
);
  initial rxd = 1'b1;
  // ==========================================================
  // Sends start, eight data bits LSB first, ninth bit, one stop level
  task automatic send(input logic [7:0] d, input logic b9, input logic stp);
    logic [10:0] f;
    f = {stp, b9, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      rxd <= f[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1; // Released line returns to idle high
  endtask : send
  // Captures nine bits and the first stop level at mid-bit
  task automatic get(output logic [8:0] c, output logic stp);
    @(negedge txd);
    repeat (BIT_CYC / 2) @(posedge clk);
    for (int i = 0; i < 9; i++) begin
      repeat (BIT_CYC) @(posedge clk);
      c[i] = txd;
    end
    repeat (BIT_CYC) @(posedge clk);
    stp = txd;
  endtask : get
endmodule : uaf_node

/* testbench/uaf_with_address_filtering_tb.sv */
// Self-checking bench for the address-filtering UART
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin errors++; \
  $display("MISMATCH %s expected %h seen %h", n, e, s); end end
module uaf_with_address_filtering_tb;
  import uaf_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic irq;
  logic rxd;
  logic txd;
  logic drv_en;
  logic [7:0] rv;
  logic [8:0] ch;
  logic stp;
  int errors = 0;
  int checks = 0;
  logic [3:0] tbl [4] = '{4'b1111, 4'b1010, 4'b1100, 4'b0100};
  logic [7:0] dat [4] = '{8'h42, 8'h11, 8'h55, 8'h22};
  logic [7:0] ed [4] = '{8'h3C, 8'h3C, 8'h3C, 8'h00};
  logic [3:0] ep = 4'b0010;
  logic [3:0] es = 4'b0011;
  logic [7:0] em [4] = '{8'h01, 8'h04, 8'h08, 8'h28};
  logic [7:0] mm [4] = '{8'h3D, 8'h04, 8'h08, 8'h28};
  // Clock of 50 ns period
  always #25 clk = ~clk;
  uaf_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .rxd(rxd), .txd(txd), .drv_en(drv_en));
  uaf_node #(.BIT_CYC(16)) i_node (.clk(clk), .txd(txd), .rxd(rxd));
  // ==========================================================
  // Register access tasks
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  task automatic rchk(input string n, input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    `CHK(n, e, v & m)
  endtask : rchk
  task automatic rx(input logic [7:0] d, input logic b9, input logic s);
    i_node.send(d, b9, s);
    repeat (8) @(posedge clk);
  endtask : rx
  task automatic summarize;
    $display("Checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : summarize
  // Watchdog against a hang
  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    summarize();
  end
  // ==========================================================
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rchk("ctl0", UAF_ADDR_CTL0, 8'hFF, UAF_RST_CTL0);
    rchk("ctl1", UAF_ADDR_CTL1, 8'hFF, UAF_RST_CTL1);
    rchk("mask", UAF_ADDR_IMSK, 8'hFF, UAF_RST_IMSK);
    rchk("div hi", UAF_ADDR_BDHI, 8'hFF, UAF_RST_BAUD[15:8]);
    rchk("div lo", UAF_ADDR_BDLO, 8'hFF, UAF_RST_BAUD[7:0]);
    rchk("unmapped", 4'hF, 8'hFF, 8'h00);
    wr(UAF_ADDR_STN, 8'h42);
    rchk("station", UAF_ADDR_STN, 8'hFF, 8'h42);
    // Transmit with even parity, then odd parity and two stops
    wr(UAF_ADDR_CTL0, 8'hD0);
    wr(UAF_ADDR_DATA, 8'hA5);
    i_node.get(ch, stp);
    `CHK("tx even", 10'h2A5, {stp, ch})
    repeat (16) @(posedge clk); // Let the stop bit finish
    rchk("tx done", UAF_ADDR_STAT, 8'h02, 8'h02);
    wr(UAF_ADDR_CTL0, 8'hDA);
    wr(UAF_ADDR_DATA, 8'h03);
    i_node.get(ch, stp);
    `CHK("tx odd", 10'h303, {stp, ch})
    repeat (16) @(posedge clk);
    `CHK("second stop", 2'b11, {txd, drv_en})
    wr(UAF_ADDR_CTL0, 8'hD0);
    wr(UAF_ADDR_CTL1, 8'h90);
    wr(UAF_ADDR_DATA, 8'h42);
    i_node.get(ch, stp);
    `CHK("tx address", 10'h342, {stp, ch})
    wr(UAF_ADDR_CTL1, 8'h00);
    // Receive good, parity error, framing error, break
    for (int i = 0; i < 4; i++) begin
      rx(ed[i], ep[i], es[i]);
      rchk("rx status", UAF_ADDR_STAT, mm[i], em[i]);
      rd(UAF_ADDR_DATA, rv);
      if (i == 0) `CHK("rx data", 8'h3C, rv)
    end
    rx(8'h11, 1'b0, 1'b1);
    rx(8'h22, 1'b0, 1'b1);
    rchk("overrun", UAF_ADDR_STAT, 8'h10, 8'h10);
    rchk("rx last", UAF_ADDR_DATA, 8'hFF, 8'h22);
    // Interrupt raised, cleared by status read
    wr(UAF_ADDR_IMSK, 8'h01);
    rx(8'h5A, 1'b0, 1'b1);
    `CHK("irq set", 1'b1, irq)
    rd(UAF_ADDR_STAT, rv);
    rd(UAF_ADDR_DATA, rv);
    repeat (3) @(posedge clk);
    `CHK("irq clear", 1'b0, irq)
    // Receiver disabled while transmitter stays enabled
    wr(UAF_ADDR_CTL0, 8'h90);
    rx(8'h5A, 1'b0, 1'b1);
    rchk("rx off", UAF_ADDR_STAT, 8'h01, 8'h00);
    wr(UAF_ADDR_CTL0, 8'hD0);
    // Multi-drop schemes: matched frame then unmatched frame
    for (int m = 0; m < 4; m++) begin
      wr(UAF_ADDR_CTL1, {1'b1, 2'(m), 5'h00});
      for (int i = 0; i < 4; i++) begin
        rx(dat[i], ~i[0], 1'b1);
        rd(UAF_ADDR_RXST, rv);
        if (i == 1 && m > 1) `CHK("first flag", 8'h02, rv & 8'h03)
        if (i == 0 && m == 1) `CHK("addr flag", 8'h01, rv & 8'h01)
        rchk("mp irq", UAF_ADDR_STAT, 8'h01, {7'h00, tbl[m][3 - i]});
        rd(UAF_ADDR_DATA, rv);
        if (i == 1 && m > 1) `CHK("mp data", 8'h11, rv)
      end
    end
    // Divider as plain timer
    wr(UAF_ADDR_CTL1, 8'h08);
    wr(UAF_ADDR_BDLO, 8'h04);
    repeat (20) @(posedge clk);
    rchk("timer", UAF_ADDR_STAT, 8'h40, 8'h40);
    summarize();
  end
endmodule : uaf_with_address_filtering_tb
bind uaf_top uaf_monitor i_mon (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .rxd(rxd), .txd(txd), .drv_en(drv_en));
